// file: shared/ps2_chan_pkg.sv
// Constants, register map and state type for the PS/2 channel controller
package ps2_chan_pkg;
   // Register byte addresses
   localparam logic [7:0] ADDR_CONTROL = 8'h00;
   localparam logic [7:0] ADDR_STATUS = 8'h08;
   localparam logic [7:0] ADDR_DATA = 8'h0C;
   localparam logic [7:0] ADDR_INT_STATUS = 8'h10;
   localparam logic [7:0] ADDR_INT_ENABLE = 8'h14;
   localparam logic [7:0] ADDR_INT_CLEAR = 8'h18;
   // Control fields
   localparam int CTRL_DIR = 0;
   localparam int CTRL_EN = 1;
   localparam int CTRL_PAR_LO = 2;
   localparam int CTRL_STOP_LO = 4;
   localparam int CTRL_W = 6;
   // Status fields
   localparam int ST_RX_READY = 0;
   localparam int ST_RX_TO = 1;
   localparam int ST_PAR_ERR = 2;
   localparam int ST_FRM_ERR = 3;
   localparam int ST_TX_IDLE = 4;
   localparam int ST_TX_TO = 5;
   localparam int ST_RX_IDLE = 6;
   localparam int ST_START_TO = 7;
   // Interrupt status / enable / clear fields
   localparam int INT_TX_IDLE = 0;
   localparam int INT_RX_TO = 1;
   localparam int INT_RX_READY = 2;
   localparam int INT_TX_TO = 3;
   localparam int INT_W = 4;
   // Expected stop level and parity selections
   localparam logic [1:0] STOP_HIGH = 2'h0;
   localparam logic [1:0] STOP_LOW = 2'h1;
   localparam logic [1:0] PAR_ODD = 2'h0;
   localparam logic [1:0] PAR_EVEN = 2'h1;
   // Falling-edge counts within a frame
   localparam logic [3:0] EDGE_FIRST = 4'h1;
   localparam logic [3:0] EDGE_PARITY = 4'hA;
   localparam logic [3:0] EDGE_STOP = 4'hB;
   localparam logic [7:0] RX_DATA_INIT = 8'hFF;
   // Timing
   localparam int CLK_MHZ = 20;
   localparam int BIT_TIME_US = 300;
   localparam int START_TIMEOUT_US = 25000;
   localparam int FRAME_TIME_US = 2000;
   localparam int TIMER_W = 20;
   typedef enum logic [2:0] {
      ST_IDLE = 3'h0,
      ST_RX = 3'h1,
      ST_TX_START = 3'h2,
      ST_TX = 3'h3,
      ST_HOLD = 3'h4
   } state_type;
endpackage

// file: rtl/ps2_channel_control_status.sv
// PS/2 channel: control, status, bit sequencing, timeouts and interrupt
module ps2_channel_control_status #(
   parameter int BIT_CYC = ps2_chan_pkg::BIT_TIME_US * ps2_chan_pkg::CLK_MHZ,
   parameter int START_CYC = ps2_chan_pkg::START_TIMEOUT_US * ps2_chan_pkg::CLK_MHZ,
   parameter int FRAME_CYC = ps2_chan_pkg::FRAME_TIME_US * ps2_chan_pkg::CLK_MHZ
) (
   input wire logic clk,
   input wire logic reset_n,
   input wire logic [7:0] addr,
   input wire logic [31:0] wrData,
   input wire logic wrEn,
   input wire logic rdEn,
   output logic [31:0] rdData,
   output logic irq,
   input wire logic kbdClockLineIn,
   output logic kbdClockLineOut,
   output logic kbdClockLineOe,
   input wire logic kbdDataLineIn,
   output logic kbdDataLineOut,
   output logic kbdDataLineOe
);
   localparam int TW = ps2_chan_pkg::TIMER_W;
   localparam logic [TW-1:0] BIT_LIM = BIT_CYC[TW-1:0];
   localparam logic [TW-1:0] START_LIM = START_CYC[TW-1:0];
   localparam logic [TW-1:0] FRAME_LIM = FRAME_CYC[TW-1:0];

   ps2_chan_pkg::state_type state_r, stateNxt;
   logic [1:0] stopSel_r, paritySel_r;
   logic enable_r, direction_r, enableD_r, directionD_r;
   logic [1:0] clkSync_r, datSync_r;
   logic clkPrev_r, clkFall, datIn;
   logic [3:0] bitCnt_r, cntNxt;
   logic [9:0] shift_r, shiftNxt;
   logic [TW-1:0] timer_r, frame_r;
   logic readSeen_r;
   logic rxReady_r, txIdle_r, txTo_r, startTo_r, rxTo_r, frmErr_r, parErr_r, rxIdle_r;
   logic [7:0] rxData_r;
   logic [ps2_chan_pkg::INT_W-1:0] intStatus_r, intEnable_r, evPrev_r, evNow;
   logic [31:0] rdData_r, rdMux;
   logic irq_r, clkOe_r, datOe_r, lineLevel_r;
   logic evRxDone, evRxSave, evParErr, evFrmErr, evRxTo, evTxTo, evStartTo, evTxDone;
   logic txStart, wrCtrl, wrStat, rdStat, rdBuf;

   // Odd parity means the data plus parity bit hold an odd count of ones
   function automatic logic parity_ok(input logic [1:0] sel, input logic ones);
      case (sel)
         ps2_chan_pkg::PAR_ODD: parity_ok = ones;
         ps2_chan_pkg::PAR_EVEN: parity_ok = !ones;
         default: parity_ok = 1'b1;
      endcase
   endfunction

   function automatic logic stop_ok(input logic [1:0] sel, input logic lvl);
      case (sel)
         ps2_chan_pkg::STOP_HIGH: stop_ok = lvl;
         ps2_chan_pkg::STOP_LOW: stop_ok = !lvl;
         default: stop_ok = 1'b1;
      endcase
   endfunction

   assign wrCtrl = wrEn && (addr == ps2_chan_pkg::ADDR_CONTROL);
   assign wrStat = wrEn && (addr == ps2_chan_pkg::ADDR_STATUS);
   assign rdStat = rdEn && (addr == ps2_chan_pkg::ADDR_STATUS);
   assign rdBuf = rdEn && (addr == ps2_chan_pkg::ADDR_DATA);
   // Not started while a received byte waits to be read
   assign txStart = wrEn && (addr == ps2_chan_pkg::ADDR_DATA) && enable_r && direction_r
      && (state_r == ps2_chan_pkg::ST_IDLE) && !rxReady_r;
   assign clkFall = clkPrev_r && !clkSync_r[1];
   assign datIn = datSync_r[1];

   // Pins come from another domain: two stages before any logic
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         clkSync_r <= 2'h3;
         datSync_r <= 2'h3;
         clkPrev_r <= 1'b1;
      end else begin
         clkSync_r <= {clkSync_r[0], kbdClockLineIn};
         datSync_r <= {datSync_r[0], kbdDataLineIn};
         clkPrev_r <= clkSync_r[1];
      end
   end

   // Control register; hardware clears direction at the end of a transmission
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         stopSel_r <= 2'h0;
         paritySel_r <= 2'h0;
         enable_r <= 1'b0;
         direction_r <= 1'b0;
      end else begin
         if (wrCtrl) begin
            stopSel_r <= wrData[ps2_chan_pkg::CTRL_STOP_LO +: 2];
            paritySel_r <= wrData[ps2_chan_pkg::CTRL_PAR_LO +: 2];
            enable_r <= wrData[ps2_chan_pkg::CTRL_EN];
            direction_r <= wrData[ps2_chan_pkg::CTRL_DIR];
         end
         if (evTxDone || evTxTo || txTo_r) begin
            direction_r <= 1'b0;
         end
      end
   end

   always_comb begin
      stateNxt = state_r;
      cntNxt = bitCnt_r;
      shiftNxt = shift_r;
      evRxDone = 1'b0;
      evRxSave = 1'b0;
      evParErr = 1'b0;
      evFrmErr = 1'b0;
      evRxTo = 1'b0;
      evTxTo = 1'b0;
      evStartTo = 1'b0;
      evTxDone = 1'b0;
      if (!enable_r) begin
         stateNxt = ps2_chan_pkg::ST_IDLE;
         evRxSave = (state_r == ps2_chan_pkg::ST_RX) && (bitCnt_r >= ps2_chan_pkg::EDGE_PARITY);
      end else begin
         case (state_r)
            ps2_chan_pkg::ST_IDLE: begin
               if (txStart) begin
                  stateNxt = ps2_chan_pkg::ST_TX_START;
                  cntNxt = 4'h0;
                  shiftNxt = {1'b1, parity_ok(paritySel_r, ^wrData[7:0]) ^ 1'b1, wrData[7:0]};
               end else if (!direction_r && !rxReady_r && clkFall) begin
                  stateNxt = ps2_chan_pkg::ST_RX;
                  cntNxt = ps2_chan_pkg::EDGE_FIRST;
                  shiftNxt = {datIn, shift_r[9:1]};
               end
            end
            ps2_chan_pkg::ST_RX: begin
               if (direction_r) begin
                  stateNxt = ps2_chan_pkg::ST_IDLE;
                  evRxSave = bitCnt_r >= ps2_chan_pkg::EDGE_PARITY;
               end else if (clkFall) begin
                  cntNxt = bitCnt_r + 4'h1;
                  shiftNxt = {datIn, shift_r[9:1]};
                  if (cntNxt == ps2_chan_pkg::EDGE_PARITY &&
                      !parity_ok(paritySel_r, ^{datIn, shift_r[9:2]})) begin
                     evParErr = 1'b1;
                     evRxTo = 1'b1;
                     stateNxt = ps2_chan_pkg::ST_HOLD;
                  end else if (cntNxt == ps2_chan_pkg::EDGE_STOP) begin
                     if (!stop_ok(stopSel_r, datIn)) begin
                        evFrmErr = 1'b1;
                        evRxTo = 1'b1;
                        stateNxt = ps2_chan_pkg::ST_HOLD;
                     end else begin
                        evRxDone = 1'b1;
                        stateNxt = ps2_chan_pkg::ST_IDLE;
                     end
                  end
               end else if (timer_r >= BIT_LIM || frame_r >= FRAME_LIM) begin
                  evRxTo = 1'b1;
                  stateNxt = ps2_chan_pkg::ST_HOLD;
               end
            end
            ps2_chan_pkg::ST_TX_START: begin
               if (!direction_r) begin
                  stateNxt = ps2_chan_pkg::ST_IDLE;
               end else if (clkFall) begin
                  stateNxt = ps2_chan_pkg::ST_TX;
                  cntNxt = ps2_chan_pkg::EDGE_FIRST;
               end else if (timer_r >= START_LIM) begin
                  evStartTo = 1'b1;
                  evTxTo = 1'b1;
                  stateNxt = ps2_chan_pkg::ST_HOLD;
               end
            end
            ps2_chan_pkg::ST_TX: begin
               if (!direction_r) begin
                  stateNxt = ps2_chan_pkg::ST_IDLE;
               end else if (clkFall) begin
                  cntNxt = bitCnt_r + 4'h1;
                  shiftNxt = {1'b1, shift_r[9:1]};
                  if (cntNxt == ps2_chan_pkg::EDGE_STOP) begin
                     evTxDone = 1'b1;
                     stateNxt = ps2_chan_pkg::ST_IDLE;
                  end
               end else if (timer_r >= BIT_LIM || frame_r >= FRAME_LIM) begin
                  evTxTo = 1'b1;
                  stateNxt = ps2_chan_pkg::ST_HOLD;
               end
            end
            ps2_chan_pkg::ST_HOLD: begin
               if (timer_r >= BIT_LIM && readSeen_r) begin
                  stateNxt = ps2_chan_pkg::ST_IDLE;
               end
            end
            default: stateNxt = ps2_chan_pkg::ST_IDLE;
         endcase
      end
   end

   // Sequencer and timers; the bit timer restarts on every falling edge
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         state_r <= ps2_chan_pkg::ST_IDLE;
         bitCnt_r <= 4'h0;
         shift_r <= 10'h3FF;
         timer_r <= '0;
         frame_r <= '0;
         readSeen_r <= 1'b0;
      end else begin
         state_r <= stateNxt;
         bitCnt_r <= cntNxt;
         shift_r <= shiftNxt;
         if (clkFall || stateNxt != state_r) begin
            timer_r <= '0;
         end else if (timer_r < START_LIM) begin
            timer_r <= timer_r + 1'b1;
         end
         // Frame time runs from the start bit until the parity bit
         if (stateNxt != state_r) begin
            frame_r <= '0;
         end else if (bitCnt_r < ps2_chan_pkg::EDGE_PARITY && frame_r < FRAME_LIM) begin
            frame_r <= frame_r + 1'b1;
         end
         readSeen_r <= (state_r == ps2_chan_pkg::ST_HOLD) && (readSeen_r || rdStat);
      end
   end

   // Receive buffer and ready flag; a new byte wins over a same-cycle read
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         rxReady_r <= 1'b0;
         rxData_r <= ps2_chan_pkg::RX_DATA_INIT;
      end else begin
         if (evRxDone || evRxSave) begin
            rxReady_r <= 1'b1;
            rxData_r <= shift_r[8:1];
         end else if (rdBuf || evRxTo) begin
            rxReady_r <= rdBuf ? 1'b0 : rxReady_r;
            rxData_r <= ps2_chan_pkg::RX_DATA_INIT;
         end
      end
   end

   // Status flags; for write-to-clear flags a same-cycle event wins
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         txIdle_r <= 1'b0;
         txTo_r <= 1'b0;
         startTo_r <= 1'b0;
         rxTo_r <= 1'b0;
         frmErr_r <= 1'b0;
         parErr_r <= 1'b0;
         rxIdle_r <= 1'b0;
         enableD_r <= 1'b0;
         directionD_r <= 1'b0;
      end else begin
         enableD_r <= enable_r;
         directionD_r <= direction_r;
         if (evTxDone || evTxTo || (directionD_r && !direction_r) || (enableD_r && !enable_r)) begin
            txIdle_r <= 1'b1;
         end else if (txStart) begin
            txIdle_r <= 1'b0;
         end
         txTo_r <= evTxTo || (txTo_r && !(wrStat && wrData[ps2_chan_pkg::ST_TX_TO]));
         startTo_r <= evStartTo || (startTo_r && !(wrStat && wrData[ps2_chan_pkg::ST_START_TO]));
         rxTo_r <= evRxTo || (rxTo_r && !(wrStat && wrData[ps2_chan_pkg::ST_RX_TO]));
         frmErr_r <= evFrmErr || (frmErr_r && !(wrStat && wrData[ps2_chan_pkg::ST_FRM_ERR]));
         parErr_r <= evParErr || (parErr_r && !(wrStat && wrData[ps2_chan_pkg::ST_PAR_ERR]));
         rxIdle_r <= (state_r != ps2_chan_pkg::ST_RX);
      end
   end

   // Rising edges of the tx-timeout, rx-ready, rx-timeout and tx-idle status flags feed the interrupt
   assign evNow = {txTo_r, rxReady_r, rxTo_r, txIdle_r};

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         evPrev_r <= '0;
         intStatus_r <= '0;
         intEnable_r <= '0;
         irq_r <= 1'b0;
      end else begin
         evPrev_r <= evNow;
         if (wrEn && addr == ps2_chan_pkg::ADDR_INT_ENABLE) begin
            intEnable_r <= wrData[ps2_chan_pkg::INT_W-1:0];
         end
         if (wrEn && addr == ps2_chan_pkg::ADDR_INT_CLEAR) begin
            intStatus_r <= (intStatus_r & ~wrData[ps2_chan_pkg::INT_W-1:0]) | (evNow & ~evPrev_r);
         end else begin
            intStatus_r <= intStatus_r | (evNow & ~evPrev_r);
         end
         irq_r <= |(intStatus_r & intEnable_r);
      end
   end

   always_comb begin
      rdMux = 32'h0000_0000;
      case (addr)
         ps2_chan_pkg::ADDR_CONTROL: rdMux[ps2_chan_pkg::CTRL_W-1:0] =
            {stopSel_r, paritySel_r, enable_r, direction_r};
         ps2_chan_pkg::ADDR_STATUS: rdMux[7:0] =
            {startTo_r, rxIdle_r, txTo_r, txIdle_r, frmErr_r, parErr_r, rxTo_r, rxReady_r};
         ps2_chan_pkg::ADDR_DATA: rdMux[7:0] = rxData_r;
         ps2_chan_pkg::ADDR_INT_STATUS: rdMux[ps2_chan_pkg::INT_W-1:0] = intStatus_r;
         ps2_chan_pkg::ADDR_INT_ENABLE: rdMux[ps2_chan_pkg::INT_W-1:0] = intEnable_r;
         default: rdMux = 32'h0000_0000;
      endcase
   end

   // Pin drive registered; one cycle of lag is far below a PS/2 bit time
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         rdData_r <= 32'h0000_0000;
         clkOe_r <= 1'b1;
         datOe_r <= 1'b0;
         lineLevel_r <= 1'b0;
      end else begin
         rdData_r <= rdEn ? rdMux : 32'h0000_0000;
         clkOe_r <= !enable_r || (state_r == ps2_chan_pkg::ST_HOLD) ||
            (state_r == ps2_chan_pkg::ST_IDLE && (direction_r || rxReady_r));
         datOe_r <= enable_r && ((state_r == ps2_chan_pkg::ST_TX_START) ||
            (state_r == ps2_chan_pkg::ST_TX && !shift_r[0]));
         lineLevel_r <= 1'b0;
      end
   end

   assign rdData = rdData_r;
   assign irq = irq_r;
   assign kbdClockLineOut = lineLevel_r;
   assign kbdClockLineOe = clkOe_r;
   assign kbdDataLineOut = lineLevel_r;
   assign kbdDataLineOe = datOe_r;
endmodule

// file: bench/ps2_channel_control_status_properties.sv
// Port-level checks for the PS/2 channel controller
module ps2_channel_control_status_properties (
   input wire logic clk,
   input wire logic reset_n,
   input wire logic [7:0] addr,
   input wire logic [31:0] wrData,
   input wire logic wrEn,
   input wire logic rdEn,
   input wire logic [31:0] rdData,
   input wire logic irq,
   input wire logic kbdClockLineIn,
   input wire logic kbdClockLineOut,
   input wire logic kbdClockLineOe,
   input wire logic kbdDataLineIn,
   input wire logic kbdDataLineOut,
   input wire logic kbdDataLineOe
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [5:1] ctrlCopy_r;
   logic [3:0] intEnCopy_r;
   logic [2:0] txAgo_r;
   default clocking @(posedge clk); endclocking
   default disable iff (!reset_n);
   // Only software moves enable and the selects, so a copy of the writes predicts them
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         ctrlCopy_r <= '0;
      end else if (wrEn && addr == ps2_chan_pkg::ADDR_CONTROL) begin
         ctrlCopy_r <= wrData[5:1];
      end
   end
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         intEnCopy_r <= '0;
      end else if (wrEn && addr == ps2_chan_pkg::ADDR_INT_ENABLE) begin
         intEnCopy_r <= wrData[3:0];
      end
   end
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         txAgo_r <= 3'h7;
      end else if (wrEn && addr == ps2_chan_pkg::ADDR_DATA) begin
         txAgo_r <= 3'h0;
      end else if (txAgo_r != 3'h7) begin
         txAgo_r <= txAgo_r + 3'h1;
      end
   end
   disabledPins_a: assert property (!ctrlCopy_r[1] && $past(!ctrlCopy_r[1], 3) |-> kbdClockLineOe && !kbdDataLineOe)
      else $error("Pins not parked while channel disabled");
   drivesLow_a: assert property (!kbdClockLineOut && !kbdDataLineOut)
      else $error("Open-drain output drives high");
   ctrlReadback_a: assert property (rdEn && addr == ps2_chan_pkg::ADDR_CONTROL |=> rdData[31:1] == {26'h0, ctrlCopy_r})
      else $error("Control read differs from written fields");
   statusUpper_a: assert property (rdEn && addr == ps2_chan_pkg::ADDR_STATUS |=> rdData[31:8] == 24'h00_0000)
      else $error("Status reserved bits not zero");
   readWindow_a: assert property (!rdEn |=> rdData == 32'h0000_0000)
      else $error("Read data outside its cycle");
   // Data bits raise the pull again mid-frame; only a pull that frees a parked clock is a start
   txCause_a: assert property ($rose(kbdDataLineOe) && $past(kbdClockLineOe) |->
      ctrlCopy_r[1] && txAgo_r < 3'h5)
      else $error("Data line pulled without an accepted buffer write");
   irqMasked_a: assert property (intEnCopy_r == 4'h0 |=> !irq)
      else $error("Interrupt raised with all sources masked");
   dataNoClock_a: assert property (kbdDataLineOe |-> !kbdClockLineOe)
      else $error("Clock pulled while host drives data");
endmodule

bind ps2_channel_control_status ps2_channel_control_status_properties u_ps2_channel_control_status_properties (
   .clk(clk), .reset_n(reset_n), .addr(addr), .wrData(wrData), .wrEn(wrEn), .rdEn(rdEn), .rdData(rdData),
   .irq(irq), .kbdClockLineIn(kbdClockLineIn), .kbdClockLineOut(kbdClockLineOut),
   .kbdClockLineOe(kbdClockLineOe), .kbdDataLineIn(kbdDataLineIn), .kbdDataLineOut(kbdDataLineOut),
   .kbdDataLineOe(kbdDataLineOe));

// file: bench/ps2_device_model.sv
// Behavioural PS/2 keyboard on the far side of the open-drain lines
module ps2_device_model (
   input wire logic hostClkOe,
   input wire logic hostDatOe,
   input wire logic sendGo,
   input wire logic [7:0] sendByte,
   input wire logic flipParity,
   input wire logic flipStop,
   input wire logic mute,
   output logic clkLine,
   output logic datLine,
   output logic [10:0] gotFrame,
   output logic busy
);
   timeunit 1ns;
   timeprecision 1ns;
   logic devClkLow = 1'b0;
   logic devDatLow = 1'b0;
   logic [10:0] frame;
   // Both lines have pull-ups, so a line nobody pulls reads high
   assign clkLine = !(hostClkOe || devClkLow);
   assign datLine = !(hostDatOe || devDatLow);
   initial begin
      busy = 1'b0;
      gotFrame = 11'h000;
      forever begin
         #50;
         // A frame may only start while the host leaves the clock released
         if (sendGo && clkLine) begin
            busy = 1'b1;
            frame = {!flipStop, (~^sendByte) ^ flipParity, sendByte, 1'b0};
            // A muted device gives up after four bits and leaves a cut frame behind
            for (int i = 0; i < (mute ? 4 : 11); i++) begin
               devDatLow = !frame[i];
               #100;
               devClkLow = 1'b1;
               #200;
               devClkLow = 1'b0;
               #100;
            end
            devDatLow = 1'b0;
            busy = 1'b0;
         end else if (!datLine && clkLine && !mute) begin
            // Sample just before each fall: host data moves a few cycles after a fall
            busy = 1'b1;
            for (int i = 0; i < 11; i++) begin
               #200;
               frame[i] = datLine;
               devClkLow = 1'b1;
               devDatLow = (i == 10);
               #200;
               devClkLow = 1'b0;
            end
            #200;
            devDatLow = 1'b0;
            gotFrame = frame;
            busy = 1'b0;
         end
      end
   end
endmodule

// file: bench/ps2_channel_control_status_test.sv
// Self-checking bench for the PS/2 channel controller
module ps2_channel_control_status_test;
   timeunit 1ns;
   timeprecision 1ns;
   localparam logic [7:0] CTL = ps2_chan_pkg::ADDR_CONTROL;
   localparam logic [7:0] STA = ps2_chan_pkg::ADDR_STATUS;
   localparam logic [7:0] DAT = ps2_chan_pkg::ADDR_DATA;
   logic clk, reset_n, wrEn, rdEn, irq, clkOe, clkOut, datOe, datOut, clkLine, datLine;
   logic sendGo, flipParity, flipStop, mute, devBusy;
   logic [7:0] addr, sendByte;
   logic [31:0] wrData, rdData;
   logic [10:0] gotFrame;
   int mismatches = 0;
   int checkCount = 0;
   ps2_channel_control_status #(.BIT_CYC(60), .START_CYC(400), .FRAME_CYC(300)) u_ps2_channel_control_status (
      .clk(clk), .reset_n(reset_n), .addr(addr), .wrData(wrData), .wrEn(wrEn), .rdEn(rdEn), .rdData(rdData),
      .irq(irq), .kbdClockLineIn(clkLine), .kbdClockLineOut(clkOut), .kbdClockLineOe(clkOe),
      .kbdDataLineIn(datLine), .kbdDataLineOut(datOut), .kbdDataLineOe(datOe));
   ps2_device_model u_ps2_device_model (.hostClkOe(clkOe), .hostDatOe(datOe), .sendGo(sendGo),
      .sendByte(sendByte), .flipParity(flipParity), .flipStop(flipStop), .mute(mute), .clkLine(clkLine),
      .datLine(datLine), .gotFrame(gotFrame), .busy(devBusy));
   initial begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end
   task automatic check(string what, logic [31:0] exp, logic [31:0] seen);
      checkCount++;
      if (seen !== exp) begin
         mismatches++;
         $display("Error %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic regWrite(logic [7:0] a, logic [31:0] d);
      @(posedge clk);
      addr <= a;
      wrData <= d;
      wrEn <= 1'b1;
      @(posedge clk);
      wrEn <= 1'b0;
   endtask
   task automatic ctrlWrite(logic [31:0] d);
      regWrite(CTL, d);
      repeat (10) @(posedge clk);
   endtask
   task automatic expectReg(string what, logic [7:0] a, logic [31:0] mask, logic [31:0] exp);
      @(posedge clk);
      addr <= a;
      rdEn <= 1'b1;
      @(posedge clk);
      rdEn <= 1'b0;
      #1 check(what, exp, rdData & mask);
   endtask
   // Status is sampled mid-frame, when the device has been clocking for a while
   task automatic waitDevice(logic [31:0] mask, logic [31:0] exp);
      int n = 0;
      while (!devBusy && n < 200) begin
         @(posedge clk);
         n++;
      end
      sendGo <= 1'b0;
      repeat (20) @(posedge clk);
      expectReg("status in frame", STA, mask, exp);
      while (devBusy && n < 800) begin
         @(posedge clk);
         n++;
      end
      check("device frame done", 32'h1, {31'h0, n < 800});
   endtask
   task automatic testReset();
      check("clock oe at reset", 32'h1, {31'h0, clkOe});
      check("data oe at reset", 32'h0, {31'h0, datOe});
      expectReg("control", CTL, 32'hFFFF_FFFF, 32'h0);
      regWrite(STA, 32'hFFFF_FFFF);
      expectReg("status", STA, 32'hFFFF_FFFF, 32'h0000_0040);
      expectReg("unmapped", 8'h04, 32'hFFFF_FFFF, 32'h0);
   endtask
   task automatic testReceive();
      logic [5:0] ctl [7] = '{6'h02, 6'h06, 6'h0A, 6'h02, 6'h12, 6'h22, 6'h02};
      logic [3:0] res [7] = '{4'h1, 4'h1, 4'h1, 4'hA, 4'h1, 4'h1, 4'h6};
      logic [6:0] flipP = 7'h46;
      logic [6:0] flipS = 7'h38;
      logic [7:0] b;
      for (int i = 0; i < 7; i++) begin
         b = 8'hA5 ^ 8'(i * 37);
         ctrlWrite({26'h0, ctl[i]});
         sendByte <= b;
         flipParity <= flipP[i];
         flipStop <= flipS[i];
         sendGo <= 1'b1;
         waitDevice(32'h0000_0040, 32'h0);
         repeat (70) @(posedge clk);
         expectReg("rx status", STA, 32'h0000_000F, {28'h0, res[i]});
         regWrite(STA, 32'h0000_00AE);
         expectReg("rx byte", DAT, 32'h0000_00FF, {24'h0, res[i][0] ? b : 8'hFF});
         expectReg("flags cleared", STA, 32'h0000_000F, 32'h0);
      end
   endtask
   // A cut frame lets the bit timer run out while receiving
   task automatic testRxTimeout();
      ctrlWrite(32'h0000_0002);
      sendByte <= 8'h3C;
      mute <= 1'b1;
      sendGo <= 1'b1;
      waitDevice(32'h0000_0040, 32'h0);
      repeat (70) @(posedge clk);
      expectReg("rx timeout status", STA, 32'h0000_000F, 32'h0000_0002);
      regWrite(STA, 32'h0000_00AE);
      expectReg("rx byte after timeout", DAT, 32'h0000_00FF, 32'h0000_00FF);
      expectReg("timeout cleared", STA, 32'h0000_000F, 32'h0);
      repeat (60) @(posedge clk);
      mute <= 1'b0;
   endtask
   task automatic testTransmit();
      regWrite(ps2_chan_pkg::ADDR_INT_CLEAR, 32'h0000_000F);
      regWrite(ps2_chan_pkg::ADDR_INT_ENABLE, 32'h0000_0001);
      ctrlWrite(32'h0000_0003);
      regWrite(DAT, 32'h0000_00C3);
      waitDevice(32'h0000_0010, 32'h0);
      check("frame on wire", {21'h0, 1'b1, ~^8'hC3, 8'hC3, 1'b0}, {21'h0, gotFrame});
      repeat (5) @(posedge clk);
      expectReg("tx idle", STA, 32'h0000_0010, 32'h0000_0010);
      expectReg("direction cleared", CTL, 32'h0000_0003, 32'h0000_0002);
      expectReg("int status", ps2_chan_pkg::ADDR_INT_STATUS, 32'h0000_0001, 32'h0000_0001);
      check("irq after tx", 32'h1, {31'h0, irq});
      regWrite(ps2_chan_pkg::ADDR_INT_CLEAR, 32'h0000_0001);
      repeat (2) @(posedge clk);
      check("irq cleared", 32'h0, {31'h0, irq});
   endtask
   task automatic testRefused();
      ctrlWrite(32'h0000_0002);
      regWrite(DAT, 32'h0000_0055);
      repeat (4) @(posedge clk);
      check("data oe in receive", 32'h0, {31'h0, datOe});
      expectReg("tx idle kept", STA, 32'h0000_0010, 32'h0000_0010);
      ctrlWrite(32'h0000_0001);
      regWrite(DAT, 32'h0000_0055);
      repeat (4) @(posedge clk);
      check("data oe disabled", 32'h0, {31'h0, datOe});
      check("clock oe disabled", 32'h1, {31'h0, clkOe});
   endtask
   task automatic testStartTimeout();
      mute <= 1'b1;
      ctrlWrite(32'h0000_0003);
      regWrite(DAT, 32'h0000_0081);
      repeat (480) @(posedge clk);
      check("clock held", 32'h1, {31'h0, clkOe});
      ctrlWrite(32'h0000_0003);
      expectReg("direction held", CTL, 32'h0000_0003, 32'h0000_0002);
      expectReg("timeout flags", STA, 32'h0000_00B0, 32'h0000_00B0);
      repeat (4) @(posedge clk);
      check("clock freed by read", 32'h0, {31'h0, clkOe});
      regWrite(STA, 32'h0000_00AE);
      mute <= 1'b0;
   endtask
   task automatic summarize();
      if (mismatches == 0 && checkCount > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask
   initial begin
      reset_n = 1'b0;
      addr = 8'h00;
      wrData = 32'h0;
      wrEn = 1'b0;
      rdEn = 1'b0;
      sendGo = 1'b0;
      sendByte = 8'h00;
      flipParity = 1'b0;
      flipStop = 1'b0;
      mute = 1'b0;
      repeat (3) @(posedge clk);
      reset_n <= 1'b1;
      testReset();
      testReceive();
      testRxTimeout();
      testTransmit();
      testRefused();
      testStartTimeout();
      summarize();
   end
   // The whole sequence needs about 2100 cycles
   initial begin
      repeat (20000) @(posedge clk);
      mismatches++;
      summarize();
   end
endmodule
